//--- vbm_pkg.sv
// Constants, register map and carrier types for the bus power monitor and drain block.
// Assumes a 125 MHz register clock and a 10-bit voltage converter with a 25 mV step.
package vbm_pkg;

   localparam int CLK_MHZ   = 125;
   localparam int ADC_W     = 10;
   localparam int ADC_LSB_MV = 25;

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL  = 8'h00;
   localparam logic [7:0] OFF_PSTAT = 8'h04;
   localparam logic [7:0] OFF_PMASK = 8'h08;
   localparam logic [7:0] OFF_ALERT = 8'h0C;
   localparam logic [7:0] OFF_AMASK = 8'h10;
   localparam logic [7:0] OFF_FAULT = 8'h14;
   localparam logic [7:0] OFF_VOLT  = 8'h18;
   localparam logic [7:0] OFF_LOTHR = 8'h1C;
   localparam logic [7:0] OFF_HITHR = 8'h20;
   localparam logic [7:0] OFF_SNKTH = 8'h24;
   localparam logic [7:0] OFF_STOPT = 8'h28;
   localparam logic [7:0] OFF_ROLE  = 8'h2C;

   // Alert bits (write one to clear)
   localparam int AL_PWR   = 0;
   localparam int AL_HI    = 1;
   localparam int AL_LO    = 2;
   localparam int AL_FAULT = 3;
   localparam int AL_W     = 4;

   // Fault bits (write one to clear)
   localparam int FL_DRAIN = 0;
   localparam int FL_LINK  = 1;
   localparam int FL_W     = 2;

   // Power status bits
   localparam int PS_PRES  = 0;
   localparam int PS_BLEED = 1;
   localparam int PS_FULL  = 2;
   localparam int PS_W     = 8;

   localparam logic [1:0] CC_OPEN  = 2'h0;
   localparam logic [3:0] ROLE_OFF = 4'hF;
   localparam logic [3:0] ROLE_RST = 4'h0;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] PMASK_RST = 8'h00;
   localparam logic [3:0] AMASK_RST = 4'h0;
   localparam logic [9:0] THR_RST  = 10'h000;
   localparam logic [9:0] HITHR_RST = 10'h3FF;
   localparam logic [9:0] SAFE0_CODE = 10'h020;

   // Timing
   localparam int T_SAFE0_MS = 650;
   localparam int SAFE0_CYC  = T_SAFE0_MS * 1000 * CLK_MHZ;
   localparam int T_DISC_MS  = 6;
   localparam int DISC_CYC   = T_DISC_MS * 1000 * CLK_MHZ;
   localparam int T_WDOG_MS  = 1000;
   localparam int WDOG_CYC   = T_WDOG_MS * 1000 * CLK_MHZ;

   typedef struct packed {
      logic             valid;
      logic [ADC_W-1:0] code;
   } vbm_adc_t;

   typedef struct packed {
      logic sink_hv;
      logic wdog_en;
      logic power_role;
      logic plug_orientation;
      logic alarm_disable;
      logic auto_drain_enable;
      logic full_load_force;
      logic bleed_load_enable;
   } vbm_ctrl_t;

   typedef enum logic {DR_IDLE, DR_FULL} vbm_drain_t;

endpackage : vbm_pkg

//--- vbm_top.sv
// Bus power monitor, drain control and host watchdog, reached over AHB-Lite.
// Assumes converter samples and path/alert levels arrive on hclk; the presence
// comparator and CC line states are pins and are synchronised here.
//
// How it works
// - presence flag tracks comparator, change raises alert
// - each sample published as voltage result
// - samples beyond alarm thresholds set alarm alerts
// - alarm disable bit suppresses both alarms
// - power alert when status AND mask nonzero
// - bleed enable bit applies bleed load
// - force bit applies full drain load
// - active source path with open CC starts full drain
// - power role zero means sink role
// - sink disconnect by threshold or presence fall
// - sink bleeds until disconnect, then full drain
// - terminations withheld until bus safe
// - automatic drain stops below safe level
// - drain timeout sets failure, load stays
// - force drain ends at stop threshold
// - watchdog runs only when enabled
// - watchdog runs on alerts, cleared by access
// - expiry forces roles off, paths off, drain
`timescale 1ns/1ps

module vbm_top #(
   parameter int         SAFE0_CYC  = vbm_pkg::SAFE0_CYC,
   parameter int         WDOG_CYC   = vbm_pkg::WDOG_CYC,
   parameter logic [9:0] SAFE0_CODE = vbm_pkg::SAFE0_CODE
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic             clk_en,
   input  wire logic             hsel,
   input  wire logic [31:0]      haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output logic                  hreadyout,
   output logic                  hresp,
   output logic [31:0]           hrdata,
   input  wire vbm_pkg::vbm_adc_t adc_sample,
   input  wire logic             bus_power_present_pin,
   input  wire logic [3:0]       cc_line_state_pin,
   input  wire logic             src_path_active,
   input  wire logic             ext_alert,
   input  wire logic             interrupt_pin_n,
   output logic                  bleed_load,
   output logic                  full_drain_load,
   output logic                  port_power_alert,
   output logic                  term_withhold,
   output logic                  path_off,
   output logic [3:0]            role_ctrl
);

   localparam int SW = $clog2(SAFE0_CYC + 1);
   localparam int WW = $clog2(WDOG_CYC + 1);

   // Bus front end
   logic                  rd_pend_q;
   logic                  wr_pend_q;
   logic [7:0]            addr_q;
   logic                  ready_q;
   logic [31:0]           rdata_q;

   // Register state
   vbm_pkg::vbm_ctrl_t    ctrl_q;
   vbm_pkg::vbm_ctrl_t    ctrl_d;
   logic [7:0]            pmask_q;
   logic [3:0]            amask_q;
   logic [9:0]            lo_thr_q;
   logic [9:0]            hi_thr_q;
   logic [9:0]            snk_thr_q;
   logic [9:0]            stop_thr_q;
   logic [9:0]            volt_q;
   logic [3:0]            role_q;
   logic [3:0]            alert_q;
   logic [3:0]            alert_d;
   logic [1:0]            fault_q;
   logic [1:0]            fault_d;

   // Pin synchronisers
   logic                  pres_s1_q;
   logic                  pres_s2_q;
   logic                  pres_prev_q;
   logic [3:0]            cc_s1_q;
   logic [3:0]            cc_s2_q;

   // Drain and watchdog
   vbm_pkg::vbm_drain_t   st_q;
   vbm_pkg::vbm_drain_t   st_d;
   logic [SW-1:0]         tmr_q;
   logic [SW-1:0]         tmr_d;
   logic [WW-1:0]         wd_q;
   logic [WW-1:0]         wd_d;
   logic                  bleed_q;
   logic                  full_q;
   logic                  pwr_alert_q;
   logic                  withhold_q;
   logic                  path_off_q;

   // Address phase decode
   wire        take     = hsel & hready & htrans[1];
   wire        take_rd  = take & ~hwrite;
   wire        take_wr  = take & hwrite;

   // Write decode in the data phase
   wire        w_ctrl   = wr_pend_q & (addr_q == vbm_pkg::OFF_CTRL);
   wire        w_pmask  = wr_pend_q & (addr_q == vbm_pkg::OFF_PMASK);
   wire        w_alert  = wr_pend_q & (addr_q == vbm_pkg::OFF_ALERT);
   wire        w_amask  = wr_pend_q & (addr_q == vbm_pkg::OFF_AMASK);
   wire        w_fault  = wr_pend_q & (addr_q == vbm_pkg::OFF_FAULT);
   wire        w_lothr  = wr_pend_q & (addr_q == vbm_pkg::OFF_LOTHR);
   wire        w_hithr  = wr_pend_q & (addr_q == vbm_pkg::OFF_HITHR);
   wire        w_snkth  = wr_pend_q & (addr_q == vbm_pkg::OFF_SNKTH);
   wire        w_stopt  = wr_pend_q & (addr_q == vbm_pkg::OFF_STOPT);
   wire        w_role   = wr_pend_q & (addr_q == vbm_pkg::OFF_ROLE);

   // Status word and role views
   wire [7:0]  pstat    = {5'h00, full_q, bleed_q, pres_s2_q};
   wire        pres_chg = pres_s2_q ^ pres_prev_q;
   wire        pres_fall = pres_prev_q & ~pres_s2_q;
   wire        sink_role = ~ctrl_q.power_role;
   wire [1:0]  cc_sel   = ctrl_q.plug_orientation ? cc_s2_q[3:2] : cc_s2_q[1:0];

   // Voltage alarms judged on each fresh sample
   wire        smp      = adc_sample.valid;
   wire        hi_hit   = smp & ~ctrl_q.alarm_disable & (adc_sample.code > hi_thr_q);
   wire        lo_hit   = smp & ~ctrl_q.alarm_disable & (adc_sample.code < lo_thr_q);

   // Disconnect sources
   wire        disc_src = ctrl_q.auto_drain_enable & src_path_active & (cc_sel == vbm_pkg::CC_OPEN);
   wire        snk_low  = volt_q < snk_thr_q;
   wire        disc_snk = ctrl_q.auto_drain_enable & sink_role
                          & (ctrl_q.sink_hv ? snk_low : pres_fall);
   wire        safe0    = volt_q < SAFE0_CODE;
   wire        stop_hit = volt_q <= stop_thr_q;
   wire        tmr_end  = tmr_q == SW'(SAFE0_CYC - 1);

   // Watchdog
   wire        al_pend  = |(alert_q & amask_q);
   wire        wd_run   = ctrl_q.wdog_en & (al_pend | ext_alert | ~interrupt_pin_n);
   wire        wd_end   = wd_q == WW'(WDOG_CYC - 1);
   wire        wd_exp   = wd_run & ~take & wd_end;

   // Read mux; unmapped addresses read zero
   wire [31:0] rd_word  =
      (addr_q == vbm_pkg::OFF_CTRL)  ? {24'h00_0000, ctrl_q}        :
      (addr_q == vbm_pkg::OFF_PSTAT) ? {24'h00_0000, pstat}         :
      (addr_q == vbm_pkg::OFF_PMASK) ? {24'h00_0000, pmask_q}       :
      (addr_q == vbm_pkg::OFF_ALERT) ? {28'h000_0000, alert_q}      :
      (addr_q == vbm_pkg::OFF_AMASK) ? {28'h000_0000, amask_q}      :
      (addr_q == vbm_pkg::OFF_FAULT) ? {30'h0000_0000, fault_q}     :
      (addr_q == vbm_pkg::OFF_VOLT)  ? {22'h00_0000, volt_q}        :
      (addr_q == vbm_pkg::OFF_LOTHR) ? {22'h00_0000, lo_thr_q}      :
      (addr_q == vbm_pkg::OFF_HITHR) ? {22'h00_0000, hi_thr_q}      :
      (addr_q == vbm_pkg::OFF_SNKTH) ? {22'h00_0000, snk_thr_q}     :
      (addr_q == vbm_pkg::OFF_STOPT) ? {22'h00_0000, stop_thr_q}    :
      (addr_q == vbm_pkg::OFF_ROLE)  ? {28'h000_0000, role_q}       :
                                       32'h0000_0000;

   // Control: software write wins over the automatic end of a force drain
   always_comb begin
      ctrl_d = ctrl_q;
      if (w_ctrl) begin
         ctrl_d = vbm_pkg::vbm_ctrl_t'(hwdata[7:0]);
      end else if (ctrl_q.full_load_force && stop_hit) begin
         ctrl_d.full_load_force = 1'b0;
      end
   end

   // Sticky alerts and faults: a set in the clearing cycle survives
   always_comb begin
      fault_d = fault_q & ~(w_fault ? hwdata[1:0] : 2'h0);
      if (st_q == vbm_pkg::DR_FULL && tmr_end) begin
         fault_d[vbm_pkg::FL_DRAIN] = 1'b1;
      end
      if (wd_exp) begin
         fault_d[vbm_pkg::FL_LINK] = 1'b1;
      end
      alert_d = alert_q & ~(w_alert ? hwdata[3:0] : 4'h0);
      if (pres_chg) begin
         alert_d[vbm_pkg::AL_PWR] = 1'b1;
      end
      if (hi_hit) begin
         alert_d[vbm_pkg::AL_HI] = 1'b1;
      end
      if (lo_hit) begin
         alert_d[vbm_pkg::AL_LO] = 1'b1;
      end
      if (fault_d != fault_q && |(fault_d & ~fault_q)) begin
         alert_d[vbm_pkg::AL_FAULT] = 1'b1;
      end
   end

   // Drain sequencer: one full-load phase shared by source, sink and watchdog exits
   always_comb begin
      st_d  = st_q;
      tmr_d = tmr_q;
      case (st_q)
         vbm_pkg::DR_IDLE: begin
            tmr_d = '0;
            if (disc_src || disc_snk || wd_exp) begin
               st_d = vbm_pkg::DR_FULL;
            end
         end
         vbm_pkg::DR_FULL: begin
            if (safe0) begin
               st_d  = vbm_pkg::DR_IDLE;
               tmr_d = '0;
            end else if (!tmr_end) begin
               tmr_d = tmr_q + 1'b1;
            end
         end
         default: begin
            st_d  = vbm_pkg::DR_IDLE;
            tmr_d = '0;
         end
      endcase
   end

   // Watchdog counter restarts on every host access while still triggered
   always_comb begin
      if (!wd_run || take || wd_end) begin
         wd_d = '0;
      end else begin
         wd_d = wd_q + 1'b1;
      end
   end

   // Bus front end: reads take one wait state so the word reflects a write just before
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_pend_q <= 1'b0;
         wr_pend_q <= 1'b0;
         addr_q    <= 8'h00;
         ready_q   <= 1'b1;
         rdata_q   <= 32'h0000_0000;
      end else if (clk_en) begin
         rd_pend_q <= take_rd;
         wr_pend_q <= take_wr;
         if (take) begin
            addr_q <= {haddr[7:2], 2'h0};
         end
         ready_q <= ~take_rd;
         if (rd_pend_q) begin
            rdata_q <= rd_word;
         end
      end
   end

   // Software registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q     <= vbm_pkg::vbm_ctrl_t'(vbm_pkg::CTRL_RST);
         pmask_q    <= vbm_pkg::PMASK_RST;
         amask_q    <= vbm_pkg::AMASK_RST;
         lo_thr_q   <= vbm_pkg::THR_RST;
         hi_thr_q   <= vbm_pkg::HITHR_RST;
         snk_thr_q  <= vbm_pkg::THR_RST;
         stop_thr_q <= vbm_pkg::THR_RST;
         role_q     <= vbm_pkg::ROLE_RST;
      end else if (clk_en) begin
         ctrl_q <= ctrl_d;
         if (w_pmask) pmask_q <= hwdata[7:0];
         if (w_amask) amask_q <= hwdata[3:0];
         if (w_lothr) lo_thr_q <= hwdata[9:0];
         if (w_hithr) hi_thr_q <= hwdata[9:0];
         if (w_snkth) snk_thr_q <= hwdata[9:0];
         if (w_stopt) stop_thr_q <= hwdata[9:0];
         if (wd_exp) begin
            role_q <= vbm_pkg::ROLE_OFF;
         end else if (w_role) begin
            role_q <= hwdata[3:0];
         end
      end
   end

   // Status, sampling and synchronisers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         alert_q     <= 4'h0;
         fault_q     <= 2'h0;
         volt_q      <= 10'h000;
         pres_s1_q   <= 1'b0;
         pres_s2_q   <= 1'b0;
         pres_prev_q <= 1'b0;
         cc_s1_q     <= 4'h0;
         cc_s2_q     <= 4'h0;
      end else if (clk_en) begin
         alert_q     <= alert_d;
         fault_q     <= fault_d;
         if (smp) begin
            volt_q <= adc_sample.code;
         end
         pres_s1_q   <= bus_power_present_pin;
         pres_s2_q   <= pres_s1_q;
         pres_prev_q <= pres_s2_q;
         cc_s1_q     <= cc_line_state_pin;
         cc_s2_q     <= cc_s1_q;
      end
   end

   // Drain state, watchdog and load outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q        <= vbm_pkg::DR_IDLE;
         tmr_q       <= '0;
         wd_q        <= '0;
         bleed_q     <= 1'b0;
         full_q      <= 1'b0;
         pwr_alert_q <= 1'b0;
         withhold_q  <= 1'b0;
         path_off_q  <= 1'b0;
      end else if (clk_en) begin
         st_q        <= st_d;
         tmr_q       <= tmr_d;
         wd_q        <= wd_d;
         bleed_q     <= ctrl_d.bleed_load_enable
                        | (st_d == vbm_pkg::DR_IDLE & ctrl_d.auto_drain_enable & ~ctrl_d.power_role);
         full_q      <= (st_d == vbm_pkg::DR_FULL) | ctrl_d.full_load_force;
         pwr_alert_q <= |(pstat & pmask_q);
         withhold_q  <= st_d == vbm_pkg::DR_FULL;
         path_off_q  <= fault_d[vbm_pkg::FL_LINK];
      end
   end

   assign hreadyout        = ready_q;
   assign hresp            = 1'b0;
   assign hrdata           = rdata_q;
   assign bleed_load       = bleed_q;
   assign full_drain_load  = full_q;
   assign port_power_alert = pwr_alert_q;
   assign term_withhold    = withhold_q;
   assign path_off         = path_off_q;
   assign role_ctrl        = role_q;

endmodule : vbm_top

//--- vbm_chk.sv
// Checker for the bus power monitor: bus answer timing, drain and watchdog outputs.
// Assumes it is bound to vbm_top and sees only that module's ports.
`timescale 1ns/1ps
module vbm_chk #(
   parameter int         WDOG_CYC   = 50,
   parameter logic [9:0] SAFE0_CODE = 10'h020
) (
   input wire logic              hclk,
   input wire logic              hresetn,
   input wire logic              clk_en,
   input wire logic              hsel,
   input wire logic [1:0]        htrans,
   input wire logic              hwrite,
   input wire logic              hready,
   input wire logic              hreadyout,
   input wire logic              hresp,
   input wire logic [31:0]       hrdata,
   input wire vbm_pkg::vbm_adc_t adc_sample,
   input wire logic              bleed_load,
   input wire logic              full_drain_load,
   input wire logic              term_withhold,
   input wire logic              path_off,
   input wire logic [3:0]        role_ctrl
);
   wire logic take = hsel && hready && htrans[1] && clk_en;
   wire logic low_smp = clk_en && adc_sample.valid && adc_sample.code < SAFE0_CODE;
   int        idle_q;

   // Cycles since the last taken transfer; the watchdog can never fire sooner
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         idle_q <= 0;
      end else if (take) begin
         idle_q <= 0;
      end else begin
         idle_q <= idle_q + 1;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence rd_ans;
      !hreadyout ##1 hreadyout;
   endsequence
   sequence safe_off;
      role_ctrl == vbm_pkg::ROLE_OFF && full_drain_load;
   endsequence

   resp_okay_a: assert property (hresp == 1'b0) else $error("hresp not OKAY");
   read_wait_a: assert property (take && !hwrite |=> rd_ans) else $error("read answer timing wrong");
   write_nowait_a: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
   rdata_hold_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata)) else $error("hrdata moved");
   reset_idle_a: assert property ($rose(hresetn) |-> !bleed_load && !full_drain_load && !path_off && role_ctrl == 4'h0) else $error("outputs not idle after reset");
   freeze_hold_a: assert property (!clk_en |=> $stable(bleed_load) && $stable(full_drain_load)) else $error("loads moved while frozen");
   withhold_load_a: assert property (term_withhold |-> full_drain_load) else $error("withhold without drain load");
   drain_stop_a: assert property (term_withhold && low_smp |-> ##[1:3] !term_withhold) else $error("auto drain kept on");
   expiry_off_a: assert property ($rose(path_off) |-> ##[0:3] safe_off) else $error("expiry did not shut down");
   expiry_idle_a: assert property ($rose(path_off) |-> idle_q >= WDOG_CYC - 2) else $error("watchdog fired early");
endmodule : vbm_chk

bind vbm_top vbm_chk #(.WDOG_CYC(WDOG_CYC), .SAFE0_CODE(SAFE0_CODE)) vbm_chk_inst (
   .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .adc_sample(adc_sample),
   .bleed_load(bleed_load), .full_drain_load(full_drain_load), .term_withhold(term_withhold),
   .path_off(path_off), .role_ctrl(role_ctrl));

//--- tb.sv
// Self-checking bench for the bus power monitor, drain and watchdog block.
// Assumes shortened drain and watchdog counts; the bench is the only bus master.
`timescale 1ns/1ps
module tb;
   localparam int SAFE0 = 200;
   localparam int WDOG  = 50;
   logic              hclk = 0, hresetn = 0, clk_en = 1, hsel = 0, hwrite = 0;
   logic              pres = 1, src = 0, ext = 0, intn = 1;
   logic [1:0]        htrans = 2'h0;
   logic [3:0]        cc = 4'h5, role;
   logic [31:0]       haddr = 32'h0, hwdata = 32'h0, hrdata, q;
   logic              hreadyout, hresp, bleed, full, ppa, term, poff;
   wire logic         hready = hreadyout;
   vbm_pkg::vbm_adc_t adc = '0;
   int                errors = 0, total_checks = 0;
   logic [9:0]        acode [6] = '{10'h101, 10'h100, 10'h07F, 10'h080, 10'h200, 10'h000};
   logic [31:0]       aexp [6] = '{32'h2, 32'h0, 32'h4, 32'h0, 32'h0, 32'h0};

   vbm_top #(.SAFE0_CYC(SAFE0), .WDOG_CYC(WDOG)) vbm_top_inst (
      .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .adc_sample(adc), .bus_power_present_pin(pres),
      .cc_line_state_pin(cc), .src_path_active(src), .ext_alert(ext), .interrupt_pin_n(intn),
      .bleed_load(bleed), .full_drain_load(full), .port_power_alert(ppa), .term_withhold(term),
      .path_off(poff), .role_ctrl(role));

   initial forever #4 hclk = ~hclk;

   task automatic summarize;
      if (errors == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : summarize

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      total_checks++;
      if (s !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask : tick

   // Waits for hready at a rising edge; a hung slave ends the run
   task automatic phase;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      if (n >= 100) begin
         errors++;
         summarize();
      end
   endtask : phase

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {24'h00_0000, a};
      phase();
      htrans <= 2'h0;
      hwdata <= d;
      phase();
      q = hrdata;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr

   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(nm, e, q);
   endtask : rd

   task automatic smp(input logic [9:0] c);
      adc <= '{valid: 1'b1, code: c};
      @(posedge hclk);
      adc.valid <= 1'b0;
      @(posedge hclk);
   endtask : smp

   initial begin
      tick(5);
      hresetn <= 1'b1;
      tick(4);
      rd("ctrl", vbm_pkg::OFF_CTRL, 32'h0);
      rd("hithr", vbm_pkg::OFF_HITHR, 32'h3FF);
      wr(8'h3C, 32'hFFFF_FFFF);
      rd("unmapped", 8'h3C, 32'h0);
      rd("pstat", vbm_pkg::OFF_PSTAT, 32'h1);
      wr(vbm_pkg::OFF_HITHR, 32'h100);
      wr(vbm_pkg::OFF_LOTHR, 32'h080);
      wr(vbm_pkg::OFF_ALERT, 32'hF);
      // The first four codes sit on or just past a threshold; the last two, far past, run with alarms disabled
      for (int i = 0; i < 6; i++) begin
         wr(vbm_pkg::OFF_CTRL, i > 3 ? 32'h8 : 32'h0);
         smp(acode[i]);
         rd("volt", vbm_pkg::OFF_VOLT, {22'h0, acode[i]});
         rd("alarm", vbm_pkg::OFF_ALERT, aexp[i]);
         wr(vbm_pkg::OFF_ALERT, 32'hF);
      end
      wr(vbm_pkg::OFF_LOTHR, 32'h0);
      wr(vbm_pkg::OFF_HITHR, 32'h3FF);
      wr(vbm_pkg::OFF_PMASK, 32'h1);
      tick(4);
      chk("ppa", 32'h1, 32'(ppa));
      wr(vbm_pkg::OFF_PMASK, 32'h6);
      tick(4);
      chk("ppa", 32'h0, 32'(ppa));
      wr(vbm_pkg::OFF_CTRL, 32'h1);
      tick(4);
      chk("bleed", 32'h1, 32'(bleed));
      chk("ppa", 32'h1, 32'(ppa));
      // A sample offered while frozen must not reach the voltage result
      clk_en <= 1'b0;
      smp(10'h155);
      tick(1);
      clk_en <= 1'b1;
      rd("pstat", vbm_pkg::OFF_PSTAT, 32'h3);
      rd("frozen", vbm_pkg::OFF_VOLT, 32'h0);
      wr(vbm_pkg::OFF_CTRL, 32'h0);
      tick(4);
      chk("bleed", 32'h0, 32'(bleed));
      wr(vbm_pkg::OFF_STOPT, 32'h050);
      smp(10'h200);
      wr(vbm_pkg::OFF_CTRL, 32'h2);
      tick(4);
      chk("full", 32'h1, 32'(full));
      smp(10'h051);
      tick(4);
      chk("full", 32'h1, 32'(full));
      smp(10'h050);
      tick(4);
      chk("full", 32'h0, 32'(full));
      rd("ctrl", vbm_pkg::OFF_CTRL, 32'h0);
      src <= 1'b1;
      cc  <= 4'h4;
      wr(vbm_pkg::OFF_CTRL, 32'h34);
      tick(6);
      chk("full", 32'h0, 32'(full));
      cc <= 4'h0;
      tick(6);
      chk("full", 32'h1, 32'(full));
      chk("term", 32'h1, 32'(term));
      src <= 1'b0;
      smp(10'h01F);
      tick(4);
      chk("full", 32'h0, 32'(full));
      chk("term", 32'h0, 32'(term));
      wr(vbm_pkg::OFF_SNKTH, 32'h0C8);
      smp(10'h190);
      wr(vbm_pkg::OFF_ALERT, 32'hF);
      wr(vbm_pkg::OFF_CTRL, 32'h84);
      tick(4);
      chk("bleed", 32'h1, 32'(bleed));
      chk("full", 32'h0, 32'(full));
      smp(10'h0C7);
      tick(4);
      chk("full", 32'h1, 32'(full));
      tick(SAFE0 / 2);
      rd("fault", vbm_pkg::OFF_FAULT, 32'h0);
      tick(SAFE0);
      rd("fault", vbm_pkg::OFF_FAULT, 32'h1);
      rd("alert", vbm_pkg::OFF_ALERT, 32'h8);
      chk("full", 32'h1, 32'(full));
      wr(vbm_pkg::OFF_CTRL, 32'h0);
      smp(10'h010);
      wr(vbm_pkg::OFF_FAULT, 32'h3);
      smp(10'h0C8);
      wr(vbm_pkg::OFF_ALERT, 32'hF);
      wr(vbm_pkg::OFF_CTRL, 32'h4);
      pres <= 1'b0;
      tick(6);
      chk("full", 32'h1, 32'(full));
      rd("alert", vbm_pkg::OFF_ALERT, 32'h1);
      wr(vbm_pkg::OFF_CTRL, 32'h0);
      // Finish the drain now, or its timeout would add a drain failure to the watchdog fault word
      smp(10'h010);
      smp(10'h190);
      ext <= 1'b1;
      tick(3 * WDOG);
      chk("poff", 32'h0, 32'(poff));
      ext  <= 1'b0;
      intn <= 1'b0;
      wr(vbm_pkg::OFF_CTRL, 32'h40);
      for (int i = 0; i < 4; i++) begin
         tick(WDOG - 10);
         rd("role", vbm_pkg::OFF_ROLE, 32'h0);
      end
      tick(WDOG + 10);
      chk("poff", 32'h1, 32'(poff));
      chk("role", 32'hF, 32'(role));
      rd("fault", vbm_pkg::OFF_FAULT, 32'h2);
      hresetn <= 1'b0;
      tick(2);
      hresetn <= 1'b1;
      tick(2);
      chk("loads", 32'h0, {27'h0, role, poff | full | bleed});
      summarize();
   end
endmodule : tb
